/* inc/mac_link_ctrl_params.svh */
`ifndef MAC_LINK_CTRL_PARAMS_SVH
`define MAC_LINK_CTRL_PARAMS_SVH

// Register byte offsets.
`define MAC_CONTROL_OFFSET 12'h100
`define LINK_CONTROL_OFFSET 12'h104
`define LPI_EXIT_DELAY_OFFSET 12'h108
`define LINK_STATUS_OFFSET 12'h10c

// Control register field positions.
`define CTRL_CLK_HALT_BIT 18
`define CTRL_LPI_EN_BIT 17
`define CTRL_AUTO_EXIT_BIT 16
`define CTRL_POLARITY_BIT 13
`define CTRL_AUTO_DUPLEX_BIT 12
`define CTRL_AUTO_SPEED_BIT 11

// Link control register field positions.
`define LINK_TX_EN_BIT 0
`define LINK_RX_EN_BIT 1
`define LINK_DUPLEX_BIT 2
`define LINK_SPEED_LSB 4

// Link status register field positions.
`define STAT_FULL_DUPLEX_BIT 0
`define STAT_SPEED_LSB 1
`define STAT_LPI_ACTIVE_BIT 3
`define STAT_RX_LPI_BIT 4
`define STAT_CLK_RUN_BIT 5

// Reset values.
`define CTRL_POLARITY_RESET 1'b1
`define LPI_EXIT_DELAY_RESET 16'h0100

// Speed detection: core cycles per half period of receive clock / 8.
`define SPEED_GIG_MAX 8'h08
`define SPEED_FAST_MAX 8'h50
`define SPEED_TIMEOUT 8'hff

// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* inc/mac_link_ctrl_pkg.sv */
`default_nettype none

package mac_link_ctrl_pkg;

    // Link speed encoding, shared by the speed field and status.
    typedef enum logic [1:0] {
        SPEED_10M,
        SPEED_100M,
        SPEED_1000M,
        SPEED_RSVD
    } speed_t;

    // Transmit low-power idle sequencer.
    typedef enum logic [1:0] {
        LPI_IDLE,
        LPI_ACTIVE,
        LPI_EXITED
    } lpi_state_t;

endpackage

`default_nettype wire

/* src/mac_eee_and_auto_link_control.sv */
`include "mac_link_ctrl_params.svh"
`default_nettype none

// How it works
// - Halt transmit clock during transmit low-power idle.
// - Clock halt ignored at 100 megabit speed.
// - Energy efficient enable turns idle behaviour on.
// - Idle requests issued even with transmitter off.
// - Idle indications decoded even with receiver off.
// - Auto exit drops idle after programmed delay.
// - Exit delay counted from idle signalling start.
// - Polarity bit selects full duplex indicator level.
// - Auto duplex follows PHY indicator, not select.
// - Detected duplex written back to select bit.
// - Without auto duplex, select bit decides duplex.
// - Auto speed samples receive clock, ignores field.
// - Detected speed written back to speed field.
// - Without auto speed, speed field decides speed.
module mac_eee_and_auto_link_control #(
    parameter int ADDR_W = 12
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic rx_clk,
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic tx_lpi_request,
    input wire logic rx_lpi_indication,
    input wire logic phy_duplex_indicator,
    output logic tx_lpi_active,
    output logic gtx_clk_enable,
    output logic rx_lpi_detected,
    output logic full_duplex,
    output logic [1:0] link_speed,
    output logic transmitter_enable,
    output logic receiver_enable
);

    // All checks below run on the core clock and pause in reset.
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Control and link state held by software.
    logic lpi_tx_clock_halt_enable_q;
    logic low_power_idle_enable_q;
    logic lpi_auto_exit_enable_q;
    logic duplex_indicator_polarity_q;
    logic auto_duplex_detect_q;
    logic auto_speed_detect_q;
    logic transmitter_enable_q;
    logic receiver_enable_q;
    logic duplex_select_q;
    mac_link_ctrl_pkg::speed_t speed_q;
    logic [15:0] lpi_auto_exit_delay_q;

    // Bus slave state.
    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic rd_ctrl_q;
    logic do_write;

    // Pin synchronisers and detection state.
    logic dup_s1_q, dup_s2_q;
    logic rxlpi_s1_q, rxlpi_s2_q;
    logic [2:0] rx_div_q;
    logic div_s1_q, div_s2_q, div_s3_q;
    logic [7:0] period_q;
    mac_link_ctrl_pkg::speed_t detected_speed_q;
    logic detected_full;
    mac_link_ctrl_pkg::speed_t eff_speed;

    // Low-power idle sequencer.
    mac_link_ctrl_pkg::lpi_state_t lpi_state_q, lpi_next;
    logic [15:0] lpi_cnt_q;
    logic lpi_active_q;
    logic gtx_clk_enable_q;
    logic rx_lpi_detected_q;
    logic full_duplex_q;
    mac_link_ctrl_pkg::speed_t link_speed_q;

    // Merges a written word into an old one under the byte strobes.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old & ~m) | (nw & m);
    endfunction

    // Builds the readable value of each register; unmapped reads zero.
    function automatic logic [31:0] reg_word(input logic [ADDR_W-1:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == ADDR_W'(`MAC_CONTROL_OFFSET)) begin
            v[`CTRL_CLK_HALT_BIT] = lpi_tx_clock_halt_enable_q;
            v[`CTRL_LPI_EN_BIT] = low_power_idle_enable_q;
            v[`CTRL_AUTO_EXIT_BIT] = lpi_auto_exit_enable_q;
            v[`CTRL_POLARITY_BIT] = duplex_indicator_polarity_q;
            v[`CTRL_AUTO_DUPLEX_BIT] = auto_duplex_detect_q;
            v[`CTRL_AUTO_SPEED_BIT] = auto_speed_detect_q;
        end else if (a == ADDR_W'(`LINK_CONTROL_OFFSET)) begin
            v[`LINK_TX_EN_BIT] = transmitter_enable_q;
            v[`LINK_RX_EN_BIT] = receiver_enable_q;
            v[`LINK_DUPLEX_BIT] = duplex_select_q;
            v[`LINK_SPEED_LSB +: 2] = speed_q;
        end else if (a == ADDR_W'(`LPI_EXIT_DELAY_OFFSET)) begin
            v[15:0] = lpi_auto_exit_delay_q;
        end else if (a == ADDR_W'(`LINK_STATUS_OFFSET)) begin
            v[`STAT_FULL_DUPLEX_BIT] = full_duplex_q;
            v[`STAT_SPEED_LSB +: 2] = link_speed_q;
            v[`STAT_LPI_ACTIVE_BIT] = lpi_active_q;
            v[`STAT_RX_LPI_BIT] = rx_lpi_detected_q;
            v[`STAT_CLK_RUN_BIT] = gtx_clk_enable_q;
        end
        return v;
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return a == ADDR_W'(`MAC_CONTROL_OFFSET) ||
               a == ADDR_W'(`LINK_CONTROL_OFFSET) ||
               a == ADDR_W'(`LPI_EXIT_DELAY_OFFSET) ||
               a == ADDR_W'(`LINK_STATUS_OFFSET);
    endfunction

    // Write address and data are taken independently and held until
    // both are present, so the master may offer them in either order.
    assign awready = !aw_held_q && !bvalid_q;
    assign wready = !w_held_q && !bvalid_q;
    assign do_write = aw_held_q && w_held_q && !bvalid_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            waddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_held_q <= 1'b1;
                waddr_q <= awaddr;
            end else if (do_write) begin
                aw_held_q <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held_q <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end else if (do_write) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Write response; unmapped addresses get a slave error.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= mapped(waddr_q) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Read channel answers one cycle after the address is taken.
    assign arready = !rvalid_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `RESP_OKAY;
            rd_ctrl_q <= 1'b0;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= reg_word(araddr);
            rresp_q <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
            rd_ctrl_q <= araddr == ADDR_W'(`MAC_CONTROL_OFFSET);
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Control register: only the defined bits are stored, so reserved
    // positions cannot hold a written value.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lpi_tx_clock_halt_enable_q <= 1'b0;
            low_power_idle_enable_q <= 1'b0;
            lpi_auto_exit_enable_q <= 1'b0;
            duplex_indicator_polarity_q <= `CTRL_POLARITY_RESET;
            auto_duplex_detect_q <= 1'b0;
            auto_speed_detect_q <= 1'b0;
        end else if (do_write && waddr_q == ADDR_W'(`MAC_CONTROL_OFFSET)) begin
            logic [31:0] n;
            n = merge(reg_word(waddr_q), wdata_q, wstrb_q);
            lpi_tx_clock_halt_enable_q <= n[`CTRL_CLK_HALT_BIT];
            low_power_idle_enable_q <= n[`CTRL_LPI_EN_BIT];
            lpi_auto_exit_enable_q <= n[`CTRL_AUTO_EXIT_BIT];
            duplex_indicator_polarity_q <= n[`CTRL_POLARITY_BIT];
            auto_duplex_detect_q <= n[`CTRL_AUTO_DUPLEX_BIT];
            auto_speed_detect_q <= n[`CTRL_AUTO_SPEED_BIT];
        end
    end

    // Link control: while detection runs, hardware overwrites the
    // duplex and speed fields each cycle, so a software write to them
    // is lost rather than fighting the detector.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            transmitter_enable_q <= 1'b0;
            receiver_enable_q <= 1'b0;
            duplex_select_q <= 1'b0;
            speed_q <= mac_link_ctrl_pkg::SPEED_10M;
        end else begin
            if (do_write && waddr_q == ADDR_W'(`LINK_CONTROL_OFFSET)) begin
                logic [31:0] n;
                n = merge(reg_word(waddr_q), wdata_q, wstrb_q);
                transmitter_enable_q <= n[`LINK_TX_EN_BIT];
                receiver_enable_q <= n[`LINK_RX_EN_BIT];
                duplex_select_q <= n[`LINK_DUPLEX_BIT];
                speed_q <= mac_link_ctrl_pkg::speed_t'(
                    n[`LINK_SPEED_LSB +: 2]);
            end
            if (auto_duplex_detect_q) begin
                duplex_select_q <= detected_full;
            end
            if (auto_speed_detect_q) begin
                speed_q <= detected_speed_q;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lpi_auto_exit_delay_q <= `LPI_EXIT_DELAY_RESET;
        end else if (do_write &&
                     waddr_q == ADDR_W'(`LPI_EXIT_DELAY_OFFSET)) begin
            lpi_auto_exit_delay_q <= 16'(merge(reg_word(waddr_q),
                                               wdata_q, wstrb_q));
        end
    end

    // Two-flop synchronisers for the PHY pins.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dup_s1_q <= 1'b0;
            dup_s2_q <= 1'b0;
            rxlpi_s1_q <= 1'b0;
            rxlpi_s2_q <= 1'b0;
        end else begin
            dup_s1_q <= phy_duplex_indicator;
            dup_s2_q <= dup_s1_q;
            rxlpi_s1_q <= rx_lpi_indication;
            rxlpi_s2_q <= rxlpi_s1_q;
        end
    end

    // Full duplex when the indicator level equals the polarity bit.
    assign detected_full = dup_s2_q == duplex_indicator_polarity_q;

    // Receive clock divided by eight; its top bit crosses as a level.
    always_ff @(posedge rx_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_div_q <= 3'h0;
        end else begin
            rx_div_q <= rx_div_q + 3'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_s1_q <= 1'b0;
            div_s2_q <= 1'b0;
            div_s3_q <= 1'b0;
        end else begin
            div_s1_q <= rx_div_q[2];
            div_s2_q <= div_s1_q;
            div_s3_q <= div_s2_q;
        end
    end

    // Core cycles between divided edges classify the speed. A receive
    // clock that stops saturates the count and keeps the last result.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            period_q <= 8'h00;
            detected_speed_q <= mac_link_ctrl_pkg::SPEED_10M;
        end else if (div_s2_q != div_s3_q) begin
            period_q <= 8'h00;
            if (period_q != `SPEED_TIMEOUT) begin
                if (period_q < `SPEED_GIG_MAX) begin
                    detected_speed_q <= mac_link_ctrl_pkg::SPEED_1000M;
                end else if (period_q < `SPEED_FAST_MAX) begin
                    detected_speed_q <= mac_link_ctrl_pkg::SPEED_100M;
                end else begin
                    detected_speed_q <= mac_link_ctrl_pkg::SPEED_10M;
                end
            end
        end else if (period_q != `SPEED_TIMEOUT) begin
            period_q <= period_q + 8'h01;
        end
    end

    // Effective speed: detector when enabled, else the software field.
    assign eff_speed = auto_speed_detect_q ? detected_speed_q
                                           : speed_q;

    // Effective duplex and speed, registered onto the outputs.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            full_duplex_q <= 1'b0;
            link_speed_q <= mac_link_ctrl_pkg::SPEED_10M;
        end else begin
            full_duplex_q <= auto_duplex_detect_q ? detected_full
                                                  : duplex_select_q;
            link_speed_q <= eff_speed;
        end
    end

    // Sequencer: the request is honoured whatever the transmitter
    // enable says; auto exit leaves idle until the request drops.
    always_comb begin
        lpi_next = lpi_state_q;
        case (lpi_state_q)
            mac_link_ctrl_pkg::LPI_IDLE: begin
                if (low_power_idle_enable_q && tx_lpi_request) begin
                    lpi_next = mac_link_ctrl_pkg::LPI_ACTIVE;
                end
            end
            mac_link_ctrl_pkg::LPI_ACTIVE: begin
                if (!low_power_idle_enable_q || !tx_lpi_request) begin
                    lpi_next = mac_link_ctrl_pkg::LPI_IDLE;
                end else if (lpi_auto_exit_enable_q &&
                             lpi_cnt_q + 16'h0001 >=
                             lpi_auto_exit_delay_q) begin
                    lpi_next = mac_link_ctrl_pkg::LPI_EXITED;
                end
            end
            default: begin
                if (!low_power_idle_enable_q || !tx_lpi_request) begin
                    lpi_next = mac_link_ctrl_pkg::LPI_IDLE;
                end
            end
        endcase
    end

    // The delay count starts at zero on entry to signalling.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lpi_state_q <= mac_link_ctrl_pkg::LPI_IDLE;
            lpi_cnt_q <= 16'h0000;
        end else begin
            lpi_state_q <= lpi_next;
            if (lpi_state_q != mac_link_ctrl_pkg::LPI_ACTIVE) begin
                lpi_cnt_q <= 16'h0000;
            end else if (lpi_cnt_q != 16'hffff) begin
                lpi_cnt_q <= lpi_cnt_q + 16'h0001;
            end
        end
    end

    // Outputs toward the PHY; the clock gate ignores 100 megabit mode.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lpi_active_q <= 1'b0;
            gtx_clk_enable_q <= 1'b1;
            rx_lpi_detected_q <= 1'b0;
        end else begin
            lpi_active_q <= lpi_next == mac_link_ctrl_pkg::LPI_ACTIVE;
            gtx_clk_enable_q <= !(lpi_tx_clock_halt_enable_q &&
                lpi_next == mac_link_ctrl_pkg::LPI_ACTIVE &&
                eff_speed != mac_link_ctrl_pkg::SPEED_100M);
            rx_lpi_detected_q <= low_power_idle_enable_q && rxlpi_s2_q;
        end
    end

    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign tx_lpi_active = lpi_active_q;
    assign gtx_clk_enable = gtx_clk_enable_q;
    assign rx_lpi_detected = rx_lpi_detected_q;
    assign full_duplex = full_duplex_q;
    assign link_speed = link_speed_q;
    assign transmitter_enable = transmitter_enable_q;
    assign receiver_enable = receiver_enable_q;

    // Checks on the guarded behaviour.
    clk_halt_lpi_a: assert property (
        $past(lpi_tx_clock_halt_enable_q &&
              eff_speed != mac_link_ctrl_pkg::SPEED_100M) && lpi_active_q
        |-> !gtx_clk_enable_q)
        else $error("Transmit clock runs during halted idle.");

    halt_100m_a: assert property (
        eff_speed == mac_link_ctrl_pkg::SPEED_100M |=> gtx_clk_enable_q)
        else $error("Transmit clock halted at 100 megabit.");

    lpi_off_a: assert property (
        !low_power_idle_enable_q |=> !lpi_active_q)
        else $error("Idle signalled while disabled.");

    lpi_entry_a: assert property (
        lpi_state_q == mac_link_ctrl_pkg::LPI_IDLE &&
        low_power_idle_enable_q && tx_lpi_request |=> lpi_active_q)
        else $error("Idle request not honoured.");

    rx_lpi_decode_a: assert property (
        low_power_idle_enable_q && rxlpi_s2_q |=> rx_lpi_detected_q)
        else $error("Received idle indication not decoded.");

    auto_exit_time_a: assert property (
        lpi_active_q && lpi_auto_exit_enable_q &&
        lpi_cnt_q + 16'h0001 >= lpi_auto_exit_delay_q |=> !lpi_active_q)
        else $error("Auto exit missed its delay.");

    exit_count_start_a: assert property (
        $rose(lpi_active_q) |-> lpi_cnt_q == 16'h0000 ##1
        lpi_cnt_q == 16'h0001)
        else $error("Exit delay not counted from idle start.");

    auto_duplex_a: assert property (
        auto_duplex_detect_q |=>
        full_duplex_q == $past(dup_s2_q == duplex_indicator_polarity_q) &&
        duplex_select_q == full_duplex_q)
        else $error("Auto duplex result wrong or not reported.");

    manual_mode_a: assert property (
        !auto_duplex_detect_q && !auto_speed_detect_q |=>
        full_duplex_q == $past(duplex_select_q) &&
        link_speed_q == $past(speed_q))
        else $error("Manual duplex or speed not followed.");

    reserved_read_a: assert property (
        rvalid_q && rd_ctrl_q |-> (rdata_q & 32'hfff8_c7ff) == 32'h0000_0000)
        else $error("Reserved control bits read non-zero.");

endmodule

`default_nettype wire

/* bench/phy_model.sv */
`default_nettype none

module phy_model (
    output logic rx_clk,
    output logic rx_lpi_indication,
    output logic phy_duplex_indicator,
    input wire logic lpi_level,
    input wire logic duplex_level
);
    timeunit 1ns;
    timeprecision 100ps;

    // The recovered receive clock runs free, out of phase with the core.
    initial rx_clk = 1'b0;
    always #7.5 rx_clk = ~rx_clk;

    // Pin levels follow what the bench asks of the far side.
    assign rx_lpi_indication = lpi_level;
    assign phy_duplex_indicator = duplex_level;
endmodule

`default_nettype wire

/* bench/tb.sv */
`include "mac_link_ctrl_params.svh"
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [11:0] CTRL = `MAC_CONTROL_OFFSET;
    localparam logic [11:0] LINK = `LINK_CONTROL_OFFSET;
    localparam logic [11:0] DLY = `LPI_EXIT_DELAY_OFFSET;
    logic core_clk = 1'b0, rst_n = 1'b0, rx_clk, awvalid, awready, wvalid;
    logic wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r, link_speed;
    logic tx_lpi_request, rx_lpi_indication, phy_duplex_indicator;
    logic tx_lpi_active, gtx_clk_enable, rx_lpi_detected, full_duplex;
    logic transmitter_enable, receiver_enable, lpi_level, duplex_level;
    int n_mismatch = 0, comparisons = 0;

    // Core clock at 100 MHz.
    always #5 core_clk = ~core_clk;

    mac_eee_and_auto_link_control uut (.core_clk, .rst_n, .rx_clk,
        .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready,
        .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready,
        .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
        .tx_lpi_request, .rx_lpi_indication, .phy_duplex_indicator,
        .tx_lpi_active, .gtx_clk_enable, .rx_lpi_detected, .full_duplex,
        .link_speed, .transmitter_enable, .receiver_enable);

    phy_model phy (.rx_clk, .rx_lpi_indication, .phy_duplex_indicator,
        .lpi_level, .duplex_level);

    task automatic final_report();
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Ready is sampled at the falling edge, so the release lands cleanly
    // on the next rising edge without racing the slave's own flops.
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        bit ta, tw, done;
        done = 0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(negedge core_clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            done = bvalid;
            r = bresp;
            @(posedge core_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        if (!done) begin
            n_mismatch++;
            final_report();
        end
    endtask

    task automatic rd(input logic [11:0] a);
        bit ta, done;
        done = 0;
        araddr <= a;
        arvalid <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(negedge core_clk);
            ta = arvalid && arready;
            done = rvalid;
            d = rdata;
            r = rresp;
            @(posedge core_clk);
            if (ta) arvalid <= 1'b0;
        end
        if (!done) begin
            n_mismatch++;
            final_report();
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    // Auto exit stays clear here, since idle is being enabled at once.
    task automatic t_regs();
        rd(`LINK_STATUS_OFFSET);
        chk(d, 32'h0000_0020);
        rd(DLY);
        chk(d, {16'h0000, `LPI_EXIT_DELAY_RESET});
        rd(CTRL);
        chk(d, 32'h0000_2000);
        chk(r, `RESP_OKAY);
        wr(CTRL, 32'hfffe_ffff);
        chk(r, `RESP_OKAY);
        rd(CTRL);
        chk(d, 32'h0006_3800);
        wr(CTRL, 32'h0000_2000);
        wr(LINK, 32'h0000_0003);
        chk({transmitter_enable, receiver_enable}, 2'h3);
        wr(LINK, 32'h0000_0000);
        wr(12'h200, 32'h0000_0000);
        chk(r, `RESP_SLVERR);
        rd(12'h200);
        chk(r, `RESP_SLVERR);
    endtask

    // Halt enabled because the far side is modelled as clock-stop capable.
    task automatic t_lpi();
        wr(CTRL, 32'h0006_2000);
        wr(LINK, 32'h0000_0020);
        tx_lpi_request <= 1'b1;
        settle(1);
        chk(tx_lpi_active, 1);
        chk(gtx_clk_enable, 0);
        @(posedge core_clk);
        wr(LINK, 32'h0000_0010);
        settle(0);
        chk(gtx_clk_enable, 1);
        @(posedge core_clk);
        wr(CTRL, 32'h0000_2000);
        lpi_level <= 1'b1;
        settle(5);
        chk(tx_lpi_active, 0);
        chk(rx_lpi_detected, 0);
        @(posedge core_clk);
        wr(CTRL, 32'h0002_2000);
        settle(4);
        chk(rx_lpi_detected, 1);
        @(posedge core_clk);
        tx_lpi_request <= 1'b0;
        lpi_level <= 1'b0;
        wr(CTRL, 32'h0000_2000);
    endtask

    // Auto exit is changed only while low-power idle is disabled.
    task automatic t_exit();
        wr(DLY, 32'h0000_0005);
        wr(CTRL, 32'h0001_2000);
        wr(CTRL, 32'h0003_2000);
        tx_lpi_request <= 1'b1;
        settle(5);
        chk(tx_lpi_active, 1);
        settle(1);
        chk(tx_lpi_active, 0);
        @(posedge core_clk);
        tx_lpi_request <= 1'b0;
        wr(CTRL, 32'h0001_2000);
        wr(CTRL, 32'h0000_2000);
    endtask

    task automatic t_duplex();
        for (int k = 0; k < 4; k++) begin
            wr(CTRL, {18'h0, k[1], 13'h1000});
            duplex_level <= k[0];
            settle(6);
            chk(full_duplex, k[0] == k[1]);
            @(posedge core_clk);
            rd(LINK);
            chk(d[2], k[0] == k[1]);
        end
        wr(CTRL, 32'h0000_0000);
        wr(LINK, 32'h0000_0004);
        settle(3);
        chk(full_duplex, 1);
        @(posedge core_clk);
    endtask

    task automatic t_speed();
        wr(LINK, 32'h0000_0010);
        wr(CTRL, 32'h0000_2800);
        settle(300);
        chk(link_speed, 2);
        @(posedge core_clk);
        rd(LINK);
        chk(d[5:4], 2);
        wr(CTRL, 32'h0000_2000);
        wr(LINK, 32'h0000_0000);
        settle(3);
        chk(link_speed, 0);
    endtask

    initial begin
        {awvalid, wvalid, arvalid, tx_lpi_request} = '0;
        {lpi_level, duplex_level, awaddr, araddr, wdata} = '0;
        bready = 1'b1;
        rready = 1'b1;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_regs();
        t_lpi();
        t_exit();
        t_duplex();
        t_speed();
        final_report();
    end
endmodule

`default_nettype wire
